// [bench/siar_regs_chk.sv]
// Port assertions for the sensor mask and indirect access bank
`timescale 1ns/10ps
`default_nettype none

module siar_regs_chk
  import siar_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Register port
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_wr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  // Status and latches
  input wire logic [SIAR_STS_W-1:0] sensor_status_word_p0,
  input wire logic [SIAR_STS_W-1:0] sensor_status_word_p1,
  input wire logic [SIAR_STS_W-1:0] rise_clr_p0,
  input wire logic [SIAR_STS_W-1:0] rise_irq_latch_p0,
  input wire logic [SIAR_STS_W-1:0] fall_irq_latch_p1,
  // Indirect port
  input wire logic [SIAR_TGT_N-1:0] ind_wr_strobe,
  input wire logic [SIAR_TGT_N-1:0] ind_rd_strobe,
  input wire logic [7:0]            indirect_offset_value,
  input wire logic [7:0]            indirect_data_value
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic rd_take;
  // A read that collides with a write is dropped, so it is not a read
  assign rd_take = reg_rd && !reg_wr;

  a_read_answer: assert property (rd_take |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd_take |=> !reg_rvalid)
    else $error("answer without read");
  a_rise_cause: assert property (((rise_irq_latch_p0 & ~$past(rise_irq_latch_p0))
    & ~($past(sensor_status_word_p0) & ~$past(sensor_status_word_p0, 2))) == 8'h00)
    else $error("rise latch set without a rising edge");
  a_fall_cause: assert property (((fall_irq_latch_p1 & ~$past(fall_irq_latch_p1))
    & ~($past(sensor_status_word_p1, 2) & ~$past(sensor_status_word_p1))) == 8'h00)
    else $error("fall latch set without a falling edge");
  a_latch_sticky: assert property (
    ($past(rise_irq_latch_p0) & ~$past(rise_clr_p0) & ~rise_irq_latch_p0) == 8'h00)
    else $error("rise latch lost without clear");
  a_wr_strobe_cause: assert property (ind_wr_strobe != '0 |-> $past(reg_wr)
    && $past(reg_addr) == SIAR_OFS_DATA && indirect_data_value == $past(reg_wdata))
    else $error("write strobe without data write");
  a_rd_strobe_cause: assert property (ind_rd_strobe != '0 |->
    ($past(reg_wr) && $past(reg_addr) == SIAR_OFS_OFFSET)
    || ($past(rd_take) && $past(reg_addr) == SIAR_OFS_DATA))
    else $error("read strobe without cause");
  a_offset_load: assert property (reg_wr && reg_addr == SIAR_OFS_OFFSET
    |=> indirect_offset_value == $past(reg_wdata))
    else $error("offset not loaded");
  a_ctl_rsvd_zero: assert property (rd_take && reg_addr == SIAR_OFS_CTL
    |=> reg_rdata[7:6] == SIAR_CTL_RSVD)
    else $error("control reserved bits not zero");

endmodule : siar_regs_chk

bind siar_regs siar_regs_chk u_chk (
  .mclk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
  .sensor_status_word_p0, .sensor_status_word_p1, .rise_clr_p0, .rise_irq_latch_p0,
  .fall_irq_latch_p1, .ind_wr_strobe, .ind_rd_strobe, .indirect_offset_value,
  .indirect_data_value
);

`default_nettype wire

// [bench/siar_tgt_model.sv]
// Behavioural model of the indirect target register blocks
`timescale 1ns/10ps
`default_nettype none

module siar_tgt_model
  import siar_pkg::*;
(
  // Clock
  input  wire logic                  mclk,
  // Access from the bank
  input  wire logic [SIAR_TGT_N-1:0] ind_wr_strobe,
  input  wire logic [7:0]            indirect_offset_value,
  input  wire logic [7:0]            indirect_data_value,
  input  wire logic [3:0]            tgt_code,
  // Read data
  output var  logic [7:0]            ind_read_data
);
  logic [7:0] mem [SIAR_TGT_N][256];
  int         idx;

  always @(posedge mclk) begin
    for (int i = 0; i < SIAR_TGT_N; i++) begin
      if (ind_wr_strobe[i]) begin
        mem[i][indirect_offset_value] <= indirect_data_value;
      end
    end
  end

  // Code 6 reads come from port 0; reserved codes fall back to block 0
  always_comb begin
    case (tgt_code)
      4'h1, 4'h6: idx = 1;
      4'h2:       idx = 2;
      4'h5:       idx = 3;
      4'h7:       idx = 4;
      default:    idx = 0;
    endcase
    ind_read_data = mem[idx][indirect_offset_value];
  end
endmodule : siar_tgt_model

`default_nettype wire

// [bench/test_siar_regs.sv]
// Self-checking bench for the sensor mask and indirect access bank
`timescale 1ns/10ps
`default_nettype none

module test_siar_regs
  import siar_pkg::*;
;
  // ********************
  // Signals
  // ********************
  logic        mclk, rst, reg_wr, reg_rd, rx_port_sel, reg_rvalid, auto_on, rdb;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ref_clock_freq_meas_mhz, ind_read_data;
  logic [7:0]  indirect_offset_value, indirect_data_value, off, a, b, c, e, d;
  logic [7:0]  sensor_status_word_p0, sensor_status_word_p1, m [4];
  logic [7:0]  rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1;
  logic [7:0]  rise_irq_latch_p0, rise_irq_latch_p1, fall_irq_latch_p0, fall_irq_latch_p1;
  logic [4:0]  ind_wr_strobe, ind_rd_strobe;
  logic [3:0]  tgt_code, sel;
  logic [7:0]  shadow [5][256];
  logic [7:0]  exp_rd [$];
  logic [25:0] exp_st [$];
  logic [25:0] ev;
  int          checks, fail_count, cycles;

  siar_regs u_dut (
    .mclk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
    .rx_port_sel, .sensor_status_word_p0, .sensor_status_word_p1, .rise_clr_p0,
    .rise_clr_p1, .fall_clr_p0, .fall_clr_p1, .rise_irq_latch_p0, .rise_irq_latch_p1,
    .fall_irq_latch_p0, .fall_irq_latch_p1, .ref_clock_freq_meas_mhz, .ind_wr_strobe,
    .ind_rd_strobe, .indirect_offset_value, .indirect_data_value, .ind_read_data
  );
  siar_tgt_model u_tgt (
    .mclk, .ind_wr_strobe, .indirect_offset_value, .indirect_data_value, .tgt_code,
    .ind_read_data
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ********************
  // Tasks
  // ********************
  task automatic cmp(input string n, input logic [25:0] x, input logic [25:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : cmp

  task automatic conclude();
    cmp("pending notes", 26'h0, 26'(exp_rd.size() + exp_st.size()));
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Called at an edge; holds the request through the next edge
  task automatic acc(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] dd);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= dd;
    @(posedge mclk);
  endtask : acc

  task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
    acc(1'b1, 1'b0, ad, dd);
    acc(1'b0, 1'b0, ad, dd);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] x);
    exp_rd.push_back(x);
    acc(1'b0, 1'b1, ad, 8'h00);
    acc(1'b0, 1'b0, ad, 8'h00);
  endtask : rd

  function automatic logic [4:0] en_of(input logic [3:0] s, input logic w);
    case (s)
      4'h0: return 5'h01;
      4'h1: return 5'h02;
      4'h2: return 5'h04;
      4'h5: return 5'h08;
      4'h6: return w ? 5'h06 : 5'h02;
      4'h7: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : en_of

  task automatic note(input logic [4:0] w, input logic [4:0] r, input logic [7:0] dd);
    if ((w | r) != 5'h00) exp_st.push_back({w, r, off, dd});
  endtask : note

  task automatic set_ctl(input logic [3:0] s, input logic au, input logic r);
    sel = s;
    auto_on = au;
    rdb = r;
    tgt_code <= s;
    wr(SIAR_OFS_CTL, {2'b11, s, au, r});
    rd(SIAR_OFS_CTL, {SIAR_CTL_RSVD, s, au, r});
  endtask : set_ctl

  task automatic set_off(input logic [7:0] o);
    off = o;
    if (rdb) note(5'h00, en_of(sel, 1'b0), 8'h00);
    wr(SIAR_OFS_OFFSET, o);
  endtask : set_off

  // Leaves the write held; the caller releases it, so writes can run back to back
  task automatic wr_data(input logic [7:0] dd);
    logic [4:0] en;
    en = en_of(sel, 1'b1);
    note(en, 5'h00, dd);
    for (int i = 0; i < 5; i++) if (en[i]) shadow[i][off] = dd;
    if (auto_on) off++;
    acc(1'b1, 1'b0, SIAR_OFS_DATA, dd);
  endtask : wr_data

  task automatic rd_data();
    logic [4:0] en;
    logic [7:0] v;
    int         t;
    en = en_of(sel, 1'b0);
    t = 0;
    for (int i = 0; i < 5; i++) if (en[i]) t = i;
    v = shadow[t][off];
    if (auto_on) off++;
    if (auto_on && rdb) note(5'h00, en, 8'h00);
    rd(SIAR_OFS_DATA, v);
  endtask : rd_data

  // ********************
  // Result watcher and time limit
  // ********************
  always @(posedge mclk) begin
    #1;
    if (reg_rvalid !== 1'b0) cmp("read data", 26'(exp_rd.pop_front()), 26'(reg_rdata));
    if ({ind_wr_strobe, ind_rd_strobe} !== 10'h000) begin
      ev = exp_st.pop_front();
      cmp("strobe", ev, {ind_wr_strobe, ind_rd_strobe, indirect_offset_value,
        (ev[25:21] != 5'h00) ? indirect_data_value : ev[7:0]});
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, rx_port_sel, reg_addr, reg_wdata, ref_clock_freq_meas_mhz, tgt_code} = '0;
    {sensor_status_word_p0, sensor_status_word_p1} = '0;
    {rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1} = '0;
    void'($urandom(28603));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(SIAR_OFS_CTL, 8'h00);
    rd(SIAR_OFS_OFFSET, SIAR_RST_OFFSET);
    rd(SIAR_OFS_FREQ, SIAR_RST_FREQ);
    foreach (m[i]) m[i] = 8'($urandom);
    for (int p = 0; p < 2; p++) begin
      rx_port_sel <= p[0];
      rd(SIAR_OFS_RISE_MASK, SIAR_RST_MASK);
      rd(SIAR_OFS_FALL_MASK, SIAR_RST_MASK);
      wr(SIAR_OFS_RISE_MASK, m[2*p]);
      wr(SIAR_OFS_FALL_MASK, m[2*p+1]);
    end
    for (int p = 0; p < 2; p++) begin
      rx_port_sel <= p[0];
      rd(SIAR_OFS_RISE_MASK, m[2*p]);
      rd(SIAR_OFS_FALL_MASK, m[2*p+1]);
    end
    {a, b, c, e} = $urandom;
    sensor_status_word_p0 <= a;
    sensor_status_word_p1 <= b;
    repeat (3) @(posedge mclk);
    {rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1} <= '1;
    @(posedge mclk);
    {rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1} <= '0;
    @(posedge mclk);
    sensor_status_word_p0 <= c;
    sensor_status_word_p1 <= e;
    repeat (3) @(posedge mclk);
    cmp("rise latch p0", 26'(c & ~a & m[0]), 26'(rise_irq_latch_p0));
    cmp("fall latch p0", 26'(a & ~c & m[1]), 26'(fall_irq_latch_p0));
    cmp("rise latch p1", 26'(e & ~b & m[2]), 26'(rise_irq_latch_p1));
    cmp("fall latch p1", 26'(b & ~e & m[3]), 26'(fall_irq_latch_p1));
    // Edge lands in the clearing cycle: the new edge must survive the clear
    sensor_status_word_p0 <= ~c;
    {rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1} <= '1;
    @(posedge mclk);
    {rise_clr_p0, rise_clr_p1, fall_clr_p0, fall_clr_p1} <= '0;
    repeat (2) @(posedge mclk);
    cmp("rise set wins p0", 26'(~c & m[0]), 26'(rise_irq_latch_p0));
    cmp("fall set wins p0", 26'(c & m[1]), 26'(fall_irq_latch_p0));
    cmp("cleared p1", 26'h0, 26'(rise_irq_latch_p1 | fall_irq_latch_p1));
    d = 8'($urandom);
    ref_clock_freq_meas_mhz <= d;
    wr(SIAR_OFS_FREQ, ~d);
    rd(SIAR_OFS_FREQ, d);
    rd(SIAR_OFS_FREQ, d);
    wr(SIAR_OFS_RSVD_HI_A, 8'h5a);
    rd(SIAR_OFS_RSVD_HI_A, SIAR_RSVD_READ);
    rd(8'h10, SIAR_RSVD_READ);
    for (int s = 0; s < 16; s++) begin
      d = 8'($urandom);
      set_ctl(4'(s), 1'b1, 1'b1);
      set_off(8'hfe);
      wr_data(d);
      wr_data(~d);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      set_off(8'hfe);
      rd_data();
      rd_data();
    end
    set_ctl(SIAR_TGT_RX1, 1'b0, 1'b0);
    set_off(8'hfe);
    rd_data();
    // Read colliding with a write is dropped; only the write lands
    acc(1'b1, 1'b1, SIAR_OFS_OFFSET, 8'h3c);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    rd(SIAR_OFS_OFFSET, 8'h3c);
    repeat (4) @(posedge mclk);
    // Second reset in mid-run must bring the latches, control, rise mask and offset back to their reset values
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmp("latches after reset", 26'h0, 26'(rise_irq_latch_p0 | rise_irq_latch_p1 |
      fall_irq_latch_p0 | fall_irq_latch_p1));
    rd(SIAR_OFS_CTL, 8'h00);
    rd(SIAR_OFS_RISE_MASK, SIAR_RST_MASK);
    rd(SIAR_OFS_OFFSET, SIAR_RST_OFFSET);
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule : test_siar_regs

`default_nettype wire

// [design/siar_edge_det.sv]
// Edge detector and sticky latches for one receive port's sensor status
`timescale 1ns/10ps
`default_nettype none

module siar_edge_det
  import siar_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Port link to the core
  siar_edge_if.det  eif
);

  logic [SIAR_STS_W-1:0] prev_reg;
  logic [SIAR_STS_W-1:0] prev_next;
  logic                  primed_reg;
  logic                  primed_next;
  logic [SIAR_STS_W-1:0] rise_reg;
  logic [SIAR_STS_W-1:0] rise_next;
  logic [SIAR_STS_W-1:0] fall_reg;
  logic [SIAR_STS_W-1:0] fall_next;
  logic [SIAR_STS_W-1:0] rise_ev;
  logic [SIAR_STS_W-1:0] fall_ev;

  always_comb begin
    prev_next   = eif.status;
    primed_next = 1'b1;
    // No edge is claimed on the first cycle after reset, prev holds no real sample yet
    rise_ev     = eif.status & ~prev_reg & eif.rise_mask & {SIAR_STS_W{primed_reg}};
    fall_ev     = ~eif.status & prev_reg & eif.fall_mask & {SIAR_STS_W{primed_reg}};
    // Set beats clear so an edge in the clearing cycle is kept
    rise_next   = (rise_reg & ~eif.rise_clr) | rise_ev;
    fall_next   = (fall_reg & ~eif.fall_clr) | fall_ev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_reg   <= SIAR_RST_MASK;
      primed_reg <= SIAR_RST_FLAG;
      rise_reg   <= SIAR_RST_MASK;
      fall_reg   <= SIAR_RST_MASK;
    end else begin
      prev_reg   <= prev_next;
      primed_reg <= primed_next;
      rise_reg   <= rise_next;
      fall_reg   <= fall_next;
    end
  end

  assign eif.rise_latch = rise_reg;
  assign eif.fall_latch = fall_reg;

endmodule : siar_edge_det

`default_nettype wire

// [design/siar_regs.sv]
// Sensor edge interrupt masks, reference clock readout and indirect access port
//
// What this block does
// - A rising edge on a sensor status bit whose rise mask bit is set is latched as a rise interrupt.
// - A falling edge on a sensor status bit whose fall mask bit is set is latched as a fall interrupt.
// - Each receive port has its own pair of mask registers and the port select chooses which one is accessed.
// - The reference clock frequency in whole MHz reads back as a read-only byte that resets to zero.
// - Bits 5 to 2 of the control register select the indirect target, with unlisted codes reserved.
// - Target code 0110 sends an indirect write to both receive ports at once.
// - With auto-increment on, the indirect offset steps by one after each indirect read or write; a data read in the cycle after a data write shares its step.
// - With the read bit on, writing the offset register sends a read strobe to the selected target.
// - With read and auto-increment both on, each host read of the data register is followed by a new read strobe.
// - The offset register holds a full 8-bit offset in bits 7 to 0.
// - Control bits 7 and 6 read as zero and the select, auto-increment and read fields reset to zero.
// - Writing the data register writes that byte to the target, reading it returns the target's value.
`timescale 1ns/10ps
`default_nettype none

module siar_regs
  import siar_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Register access port
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_rd,
  output var  logic [7:0]            reg_rdata,
  output var  logic                  reg_rvalid,
  input  wire logic                  rx_port_sel,
  // Sensor status and interrupt latches
  input  wire logic [SIAR_STS_W-1:0] sensor_status_word_p0,
  input  wire logic [SIAR_STS_W-1:0] sensor_status_word_p1,
  input  wire logic [SIAR_STS_W-1:0] rise_clr_p0,
  input  wire logic [SIAR_STS_W-1:0] rise_clr_p1,
  input  wire logic [SIAR_STS_W-1:0] fall_clr_p0,
  input  wire logic [SIAR_STS_W-1:0] fall_clr_p1,
  output var  logic [SIAR_STS_W-1:0] rise_irq_latch_p0,
  output var  logic [SIAR_STS_W-1:0] rise_irq_latch_p1,
  output var  logic [SIAR_STS_W-1:0] fall_irq_latch_p0,
  output var  logic [SIAR_STS_W-1:0] fall_irq_latch_p1,
  // Reference clock measurement
  input  wire logic [7:0]            ref_clock_freq_meas_mhz,
  // Indirect access to target blocks
  output var  logic [SIAR_TGT_N-1:0] ind_wr_strobe,
  output var  logic [SIAR_TGT_N-1:0] ind_rd_strobe,
  output var  logic [7:0]            indirect_offset_value,
  output var  logic [7:0]            indirect_data_value,
  input  wire logic [7:0]            ind_read_data
);

  // ********************************************
  // Helpers
  // ********************************************

  // Maps a target code to per-block strobe enables; reserved codes strobe nothing
  function automatic logic [SIAR_TGT_N-1:0] target_enables(
    input logic [3:0] sel,
    input logic       is_write
  );
    logic [SIAR_TGT_N-1:0] en;
    en = '0;
    case (sel)
      SIAR_TGT_PATGEN: begin
        en[SIAR_EN_PATGEN] = 1'b1;
      end
      SIAR_TGT_RX0: begin
        en[SIAR_EN_RX0] = 1'b1;
      end
      SIAR_TGT_RX1: begin
        en[SIAR_EN_RX1] = 1'b1;
      end
      SIAR_TGT_SHARED: begin
        en[SIAR_EN_SHARED] = 1'b1;
      end
      SIAR_TGT_BOTH_RX: begin
        // Broadcast only makes sense for writes; reads come from port 0
        en[SIAR_EN_RX0] = 1'b1;
        en[SIAR_EN_RX1] = is_write;
      end
      SIAR_TGT_VIDOUT: begin
        en[SIAR_EN_VIDOUT] = 1'b1;
      end
      default: begin
        en = '0;
      end
    endcase
    return en;
  endfunction : target_enables

  function automatic logic in_range(
    input logic [7:0] addr,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    return (addr >= lo) && (addr <= hi);
  endfunction : in_range

  // ********************************************
  // State
  // ********************************************
  logic [SIAR_STS_W-1:0] rise_mask_reg  [SIAR_PORTS];
  logic [SIAR_STS_W-1:0] rise_mask_next [SIAR_PORTS];
  logic [SIAR_STS_W-1:0] fall_mask_reg  [SIAR_PORTS];
  logic [SIAR_STS_W-1:0] fall_mask_next [SIAR_PORTS];
  logic [7:0]            freq_reg;
  logic [7:0]            freq_next;
  logic [3:0]            sel_reg;
  logic [3:0]            sel_next;
  logic                  auto_reg;
  logic                  auto_next;
  logic                  read_reg;
  logic                  read_next;
  logic [7:0]            offset_reg;
  logic [7:0]            offset_next;
  logic [7:0]            wdata_reg;
  logic [7:0]            wdata_next;
  logic [SIAR_TGT_N-1:0] wr_str_reg;
  logic [SIAR_TGT_N-1:0] wr_str_next;
  logic [SIAR_TGT_N-1:0] rd_str_reg;
  logic [SIAR_TGT_N-1:0] rd_str_next;
  logic                  wr_inc_reg;
  logic                  wr_inc_next;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [7:0]            ctl_view;

  // ********************************************
  // Next-state logic
  // ********************************************
  assign ctl_view = {SIAR_CTL_RSVD, sel_reg, auto_reg, read_reg};

  always_comb begin
    rise_mask_next = rise_mask_reg;
    fall_mask_next = fall_mask_reg;
    // Sampled every cycle; the source is asynchronous so a read may catch a changing value
    freq_next      = ref_clock_freq_meas_mhz;
    sel_next       = sel_reg;
    auto_next      = auto_reg;
    read_next      = read_reg;
    offset_next    = offset_reg;
    wdata_next     = wdata_reg;
    wr_str_next    = '0;
    rd_str_next    = '0;
    wr_inc_next    = 1'b0;
    rdata_next     = rdata_reg;
    rvalid_next    = 1'b0;

    // Step after the write strobe has gone out with the old offset
    if (wr_inc_reg && auto_reg) begin
      offset_next = offset_reg + SIAR_OFS_STEP;
    end

    if (reg_wr) begin
      // A write in the same cycle as a read wins; the read is dropped
      case (reg_addr)
        SIAR_OFS_RISE_MASK: begin
          rise_mask_next[rx_port_sel] = reg_wdata;
        end
        SIAR_OFS_FALL_MASK: begin
          fall_mask_next[rx_port_sel] = reg_wdata;
        end
        SIAR_OFS_CTL: begin
          sel_next  = reg_wdata[SIAR_CTL_SEL_MSB:SIAR_CTL_SEL_LSB];
          auto_next = reg_wdata[SIAR_CTL_AUTO_BIT];
          read_next = reg_wdata[SIAR_CTL_READ_BIT];
        end
        SIAR_OFS_OFFSET: begin
          offset_next = reg_wdata;
          if (read_reg) begin
            rd_str_next = target_enables(sel_reg, 1'b0);
          end
        end
        SIAR_OFS_DATA: begin
          wdata_next  = reg_wdata;
          wr_str_next = target_enables(sel_reg, 1'b1);
          wr_inc_next = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (reg_rd) begin
      rvalid_next = 1'b1;
      case (reg_addr)
        SIAR_OFS_RISE_MASK: begin
          rdata_next = rise_mask_reg[rx_port_sel];
        end
        SIAR_OFS_FALL_MASK: begin
          rdata_next = fall_mask_reg[rx_port_sel];
        end
        SIAR_OFS_FREQ: begin
          rdata_next = freq_reg;
        end
        SIAR_OFS_CTL: begin
          rdata_next = ctl_view;
        end
        SIAR_OFS_OFFSET: begin
          rdata_next = offset_reg;
        end
        SIAR_OFS_DATA: begin
          rdata_next = ind_read_data;
          if (auto_reg) begin
            offset_next = offset_reg + SIAR_OFS_STEP;
            if (read_reg) begin
              // Strobe leaves together with the stepped offset
              rd_str_next = target_enables(sel_reg, 1'b0);
            end
          end
        end
        default: begin
          // Reserved blocks and unmapped offsets read as zero
          rdata_next = SIAR_RSVD_READ;
          if (in_range(reg_addr, SIAR_OFS_RSVD_LO_A, SIAR_OFS_RSVD_LO_B) ||
              in_range(reg_addr, SIAR_OFS_RSVD_HI_A, SIAR_OFS_RSVD_HI_B)) begin
            rdata_next = SIAR_RSVD_READ;
          end
        end
      endcase
    end
  end

  // ********************************************
  // Registers
  // ********************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < SIAR_PORTS; p++) begin
        rise_mask_reg[p] <= SIAR_RST_MASK;
        fall_mask_reg[p] <= SIAR_RST_MASK;
      end
      freq_reg   <= SIAR_RST_FREQ;
      sel_reg    <= SIAR_RST_SEL;
      auto_reg   <= SIAR_RST_FLAG;
      read_reg   <= SIAR_RST_FLAG;
      offset_reg <= SIAR_RST_OFFSET;
      wdata_reg  <= SIAR_RST_MASK;
      wr_str_reg <= '0;
      rd_str_reg <= '0;
      wr_inc_reg <= SIAR_RST_FLAG;
      rdata_reg  <= SIAR_RSVD_READ;
      rvalid_reg <= SIAR_RST_FLAG;
    end else begin
      rise_mask_reg <= rise_mask_next;
      fall_mask_reg <= fall_mask_next;
      freq_reg      <= freq_next;
      sel_reg       <= sel_next;
      auto_reg      <= auto_next;
      read_reg      <= read_next;
      offset_reg    <= offset_next;
      wdata_reg     <= wdata_next;
      wr_str_reg    <= wr_str_next;
      rd_str_reg    <= rd_str_next;
      wr_inc_reg    <= wr_inc_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // ********************************************
  // Per-port edge detectors
  // ********************************************
  siar_edge_if eif [SIAR_PORTS] ();

  for (genvar p = 0; p < SIAR_PORTS; p++) begin : g_port
    assign eif[p].rise_mask = rise_mask_reg[p];
    assign eif[p].fall_mask = fall_mask_reg[p];
    siar_edge_det u_det (
      .mclk (mclk),
      .rst  (rst),
      .eif  (eif[p])
    );
  end

  assign eif[0].status   = sensor_status_word_p0;
  assign eif[1].status   = sensor_status_word_p1;
  assign eif[0].rise_clr = rise_clr_p0;
  assign eif[1].rise_clr = rise_clr_p1;
  assign eif[0].fall_clr = fall_clr_p0;
  assign eif[1].fall_clr = fall_clr_p1;

  // ********************************************
  // Outputs
  // ********************************************
  assign rise_irq_latch_p0     = eif[0].rise_latch;
  assign rise_irq_latch_p1     = eif[1].rise_latch;
  assign fall_irq_latch_p0     = eif[0].fall_latch;
  assign fall_irq_latch_p1     = eif[1].fall_latch;
  assign reg_rdata             = rdata_reg;
  assign reg_rvalid            = rvalid_reg;
  assign ind_wr_strobe         = wr_str_reg;
  assign ind_rd_strobe         = rd_str_reg;
  assign indirect_offset_value = offset_reg;
  assign indirect_data_value   = wdata_reg;

endmodule : siar_regs

`default_nettype wire

// [shared/siar_edge_if.sv]
// Carrier between the register core and one port's edge detector
`timescale 1ns/10ps
`default_nettype none

interface siar_edge_if;
  import siar_pkg::*;
  logic [SIAR_STS_W-1:0] status;
  logic [SIAR_STS_W-1:0] rise_mask;
  logic [SIAR_STS_W-1:0] fall_mask;
  logic [SIAR_STS_W-1:0] rise_clr;
  logic [SIAR_STS_W-1:0] fall_clr;
  logic [SIAR_STS_W-1:0] rise_latch;
  logic [SIAR_STS_W-1:0] fall_latch;

  modport core (
    output status, rise_mask, fall_mask, rise_clr, fall_clr,
    input  rise_latch, fall_latch
  );
  modport det (
    input  status, rise_mask, fall_mask, rise_clr, fall_clr,
    output rise_latch, fall_latch
  );
endinterface : siar_edge_if

`default_nettype wire

// [shared/siar_pkg.sv]
// Constants and types for the sensor interrupt mask and indirect access register bank
package siar_pkg;

  // ********************************************
  // Geometry
  // ********************************************
  localparam int SIAR_PORTS  = 2;
  localparam int SIAR_STS_W  = 8;
  localparam int SIAR_TGT_N  = 5;

  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [7:0] SIAR_OFS_RISE_MASK  = 8'h7e;
  localparam logic [7:0] SIAR_OFS_FALL_MASK  = 8'h7f;
  localparam logic [7:0] SIAR_OFS_RSVD_LO_A  = 8'ha0;
  localparam logic [7:0] SIAR_OFS_RSVD_LO_B  = 8'ha4;
  localparam logic [7:0] SIAR_OFS_FREQ       = 8'ha5;
  localparam logic [7:0] SIAR_OFS_RSVD_HI_A  = 8'ha7;
  localparam logic [7:0] SIAR_OFS_RSVD_HI_B  = 8'haf;
  localparam logic [7:0] SIAR_OFS_CTL        = 8'hb0;
  localparam logic [7:0] SIAR_OFS_OFFSET     = 8'hb1;
  localparam logic [7:0] SIAR_OFS_DATA       = 8'hb2;

  // ********************************************
  // Control register fields
  // ********************************************
  localparam int SIAR_CTL_READ_BIT = 0;
  localparam int SIAR_CTL_AUTO_BIT = 1;
  localparam int SIAR_CTL_SEL_LSB  = 2;
  localparam int SIAR_CTL_SEL_MSB  = 5;

  // ********************************************
  // Reset and fill values
  // ********************************************
  localparam logic [7:0] SIAR_RST_MASK   = 8'h00;
  localparam logic [7:0] SIAR_RST_FREQ   = 8'h00;
  localparam logic [3:0] SIAR_RST_SEL    = 4'h0;
  localparam logic       SIAR_RST_FLAG   = 1'b0;
  localparam logic [7:0] SIAR_RST_OFFSET = 8'h00;
  localparam logic [7:0] SIAR_RSVD_READ  = 8'h00;
  localparam logic [1:0] SIAR_CTL_RSVD   = 2'h0;
  localparam logic [7:0] SIAR_OFS_STEP   = 8'h01;

  // ********************************************
  // Indirect targets
  // ********************************************
  typedef enum logic [3:0] {
    SIAR_TGT_PATGEN  = 4'h0,
    SIAR_TGT_RX0     = 4'h1,
    SIAR_TGT_RX1     = 4'h2,
    SIAR_TGT_SHARED  = 4'h5,
    SIAR_TGT_BOTH_RX = 4'h6,
    SIAR_TGT_VIDOUT  = 4'h7
  } siar_target_t;

  // Bit positions of the per-target strobe vectors
  localparam int SIAR_EN_PATGEN = 0;
  localparam int SIAR_EN_RX0    = 1;
  localparam int SIAR_EN_RX1    = 2;
  localparam int SIAR_EN_SHARED = 3;
  localparam int SIAR_EN_VIDOUT = 4;

endpackage : siar_pkg
